// ### logic/pqt_pkg.sv
/*
 * Package for the pattern-qualified trigger: register map, field layout,
 * mode encodings and timing constants.
 * Assumes a 25 MHz trigger clock and a 32-bit Avalon-MM register bus.
 */
package pqt_pkg;

    // ==========================================================
    // Geometry and timing
    // ==========================================================
    localparam int N_IN = 5;
    localparam int CLK_HZ = 25000000;
    localparam int CLK_NS = 40;
    localparam int HOLD_MIN_NS = 10;
    localparam int HOLD_MIN_CYC = (HOLD_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int MAX_EVENTS = 99999999;
    localparam int MAX_TIME_S = 20;
    localparam longint MAX_TIME_CYC = longint'(MAX_TIME_S) * longint'(CLK_HZ);
    localparam int CNT_W = 32;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PAT = 4'h4;
    localparam logic [3:0] REG_HOLD = 4'h8;
    localparam logic [3:0] REG_WAIT = 4'hC;
    localparam logic [3:0] REG_STAT = 4'h0 + 4'h0;
    localparam logic [5:0] REG_STAT_FULL = 6'h10;
    localparam logic [5:0] REG_COUNT_FULL = 6'h14;

    // ==========================================================
    // CTRL fields
    // ==========================================================
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_EXIT = 3;
    localparam int CTRL_HOLD_LO = 4;
    localparam int CTRL_WAIT_LO = 6;
    localparam int CTRL_ABSENT = 8;
    localparam int CTRL_SRC_LO = 9;
    localparam int CTRL_SLOPE_NEG = 12;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // PAT: bits [4:0] care mask, bits [12:8] required level
    localparam int PAT_CARE_LO = 0;
    localparam int PAT_LVL_LO = 8;

    typedef enum logic [1:0] {
        PQT_MODE_PATTERN = 2'h0,
        PQT_MODE_STATE = 2'h1,
        PQT_MODE_EDGE = 2'h2
    } pqt_mode_t;

    typedef enum logic [1:0] {
        PQT_HOLD_NONE = 2'h0,
        PQT_HOLD_TIME = 2'h1,
        PQT_HOLD_EVENTS = 2'h2
    } pqt_hold_t;

    typedef enum logic [1:0] {
        PQT_WAIT_NOW = 2'h0,
        PQT_WAIT_WITHIN = 2'h1,
        PQT_WAIT_DELAY = 2'h2,
        PQT_WAIT_EVENTS = 2'h3
    } pqt_wait_t;

    typedef struct packed {
        logic enable;
        pqt_mode_t mode;
        logic on_exit;
        pqt_hold_t hold;
        pqt_wait_t wait_kind;
        logic use_absent;
        logic [2:0] source;
        logic slope_neg;
    } pqt_cfg_t;

    typedef struct packed {
        logic [N_IN-1:0] care;
        logic [N_IN-1:0] level;
    } pqt_pat_t;

endpackage : pqt_pkg

// ### logic/pqt_trigger.sv
/*
 * Pattern and qualified trigger decision logic with an Avalon-MM slave.
 * Assumes comparator states arrive asynchronously, one per input
 * (channels one to four, then the external trigger input), and that
 * the acquisition system takes the one-cycle trigger pulse.
 */
// Added by the designer: the placing of the registers and the Avalon-MM register port.
// Summary of operation
// - Pattern is the AND of selected input states, each wanted high or low.
// - Input state is high above its level, low below it.
// - Pattern present only when every required term holds.
// - Pattern trigger fires on entering or on exiting, as configured.
// - Pattern trigger supports hold-off by time or by event count.
// - Each input has its own comparator threshold, set outside.
// - In qualified modes the pattern validation enables a separate source.
// - State-qualified: enable lasts only while the pattern holds.
// - Edge-qualified: validation alone arms the trigger.
// - Qualified fire: immediately, within a time, after delay, or after events.
// - Qualified timer or counter restarts on every validation.
// - Qualification may use pattern presence or absence.
// - The trigger source is excluded from the qualifying pattern.
// - Qualified trigger fires only on a source event, never on pattern alone.
// - Wait programmable as a time or an event count.
// - State time wait: fire after delay from pattern start, pattern still on.
// - Wait timer restarts each time the pattern begins.
// - Event wait counter clears at pattern start, counts while pattern remains.
// - Trigger issued on the source event that reaches the count.
// - Timeout enabled at pattern start, disabled at pattern end.
// - An event is the source crossing its level on the selected slope.
// - Pattern built from four channels and the external input.
// - Each term is high, low or don't-care.
`timescale 1ns/100ps
module pqt_trigger
#(
    parameter int CNT_W = pqt_pkg::CNT_W
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [pqt_pkg::N_IN-1:0] comp_state,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic trigger_out
);

    // ==========================================================
    // Registers
    // ==========================================================
    pqt_pkg::pqt_cfg_t cfg_q;
    pqt_pkg::pqt_pat_t pat_q;
    logic [CNT_W-1:0] hold_val_q;
    logic [CNT_W-1:0] wait_val_q;
    logic [15:0] trig_count_q;
    logic rd_done_q;
    logic [31:0] rdata_q;

    // Answer one cycle after the request appears: waitrequest low then
    assign avs_waitrequest = (avs_read & ~rd_done_q);

    always_ff @(posedge clk)
    begin
        if (reset)
            rd_done_q <= 1'b0;
        else
            rd_done_q <= avs_read & ~rd_done_q;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cfg_q <= pqt_pkg::pqt_cfg_t'(pqt_pkg::CTRL_RST[12:0]);
            pat_q <= '0;
            hold_val_q <= '0;
            wait_val_q <= '0;
        end
        else if (avs_write)
        begin
            case ({avs_address[3:2], 2'b00})
                pqt_pkg::REG_CTRL: cfg_q <= pqt_pkg::pqt_cfg_t'({
                    avs_writedata[pqt_pkg::CTRL_EN],
                    avs_writedata[pqt_pkg::CTRL_MODE_LO +: 2],
                    avs_writedata[pqt_pkg::CTRL_EXIT],
                    avs_writedata[pqt_pkg::CTRL_HOLD_LO +: 2],
                    avs_writedata[pqt_pkg::CTRL_WAIT_LO +: 2],
                    avs_writedata[pqt_pkg::CTRL_ABSENT],
                    avs_writedata[pqt_pkg::CTRL_SRC_LO +: 3],
                    avs_writedata[pqt_pkg::CTRL_SLOPE_NEG]});
                pqt_pkg::REG_PAT: pat_q <= {
                    avs_writedata[pqt_pkg::PAT_CARE_LO +: pqt_pkg::N_IN],
                    avs_writedata[pqt_pkg::PAT_LVL_LO +: pqt_pkg::N_IN]};
                pqt_pkg::REG_HOLD: hold_val_q <= avs_writedata[CNT_W-1:0];
                pqt_pkg::REG_WAIT: wait_val_q <= avs_writedata[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Input synchroniser and edge detection
    // ==========================================================
    logic [pqt_pkg::N_IN-1:0] meta_q;
    logic [pqt_pkg::N_IN-1:0] sync_q;
    logic [pqt_pkg::N_IN-1:0] prev_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= comp_state;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // ==========================================================
    // Pattern evaluation
    // ==========================================================
    function automatic logic pat_eval(
        input logic [pqt_pkg::N_IN-1:0] st,
        input logic [pqt_pkg::N_IN-1:0] care,
        input logic [pqt_pkg::N_IN-1:0] lvl
    );
        pat_eval = &(~care | ~(st ^ lvl));
    endfunction : pat_eval

    logic qualified;
    logic [pqt_pkg::N_IN-1:0] care_eff;
    logic raw_now;
    logic raw_prev;
    logic pat_now;
    logic pat_prev;
    logic pat_begin;
    logic pat_end;
    logic src_now;
    logic src_prev;
    logic src_event;

    assign qualified = (cfg_q.mode != pqt_pkg::PQT_MODE_PATTERN);

    always_comb
    begin
        care_eff = pat_q.care;
        if (qualified && (cfg_q.source < 3'(pqt_pkg::N_IN)))
            care_eff[cfg_q.source] = 1'b0;
    end

    // Threshold per input sits in the comparator ahead of this block
    assign raw_now = pat_eval(sync_q, care_eff, pat_q.level);
    assign raw_prev = pat_eval(prev_q, care_eff, pat_q.level);
    assign pat_now = raw_now ^ (qualified & cfg_q.use_absent);
    assign pat_prev = raw_prev ^ (qualified & cfg_q.use_absent);
    assign pat_begin = pat_now & ~pat_prev;
    assign pat_end = ~pat_now & pat_prev;

    assign src_now = (cfg_q.source < 3'(pqt_pkg::N_IN)) ? sync_q[cfg_q.source] : 1'b0;
    assign src_prev = (cfg_q.source < 3'(pqt_pkg::N_IN)) ? prev_q[cfg_q.source] : 1'b0;
    assign src_event = cfg_q.slope_neg ? (src_prev & ~src_now) : (~src_prev & src_now);

    // ==========================================================
    // Qualifier: armed flag, wait timer and event counter
    // ==========================================================
    logic armed_q;
    logic [CNT_W-1:0] wcnt_q;
    logic wait_ok;
    logic fire_qual;
    logic holding;

    always_ff @(posedge clk)
    begin
        if (reset)
            armed_q <= 1'b0;
        else if (pat_begin)
            armed_q <= 1'b1;
        else if (cfg_q.mode == pqt_pkg::PQT_MODE_STATE && !pat_now)
            armed_q <= 1'b0;
        else if (cfg_q.mode == pqt_pkg::PQT_MODE_EDGE && fire_qual)
            armed_q <= 1'b0;
    end

    // One counter serves both time and event waits; the kind picks what it counts
    always_ff @(posedge clk)
    begin
        if (reset)
            wcnt_q <= '0;
        else if (pat_begin)
            wcnt_q <= '0;
        else if (armed_q && wcnt_q != '1)
        begin
            if (cfg_q.wait_kind == pqt_pkg::PQT_WAIT_EVENTS)
                wcnt_q <= wcnt_q + CNT_W'(src_event);
            else
                wcnt_q <= wcnt_q + 1'b1;
        end
    end

    always_comb
    begin
        case (cfg_q.wait_kind)
            pqt_pkg::PQT_WAIT_NOW: wait_ok = 1'b1;
            pqt_pkg::PQT_WAIT_WITHIN: wait_ok = (wcnt_q < wait_val_q);
            pqt_pkg::PQT_WAIT_DELAY: wait_ok = (wcnt_q >= wait_val_q);
            pqt_pkg::PQT_WAIT_EVENTS: wait_ok = (wcnt_q + 1'b1 >= wait_val_q);
            default: wait_ok = 1'b0;
        endcase
    end

    // Source event alone ever fires; the pattern only gates it
    assign fire_qual = armed_q & src_event & wait_ok
        & ((cfg_q.mode == pqt_pkg::PQT_MODE_EDGE) | pat_now);

    // ==========================================================
    // Pattern trigger and hold-off
    // ==========================================================
    logic fire_pat;
    logic fire_any;
    logic [CNT_W-1:0] hcnt_q;
    logic hold_q;

    assign fire_pat = cfg_q.on_exit ? pat_end : pat_begin;
    assign fire_any = cfg_q.enable & ~holding
        & (qualified ? fire_qual : fire_pat);

    // Hold-off events are the same kind of potential trigger being suppressed
    assign holding = hold_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            hold_q <= 1'b0;
            hcnt_q <= '0;
        end
        else if (fire_any && cfg_q.hold != pqt_pkg::PQT_HOLD_NONE)
        begin
            hold_q <= 1'b1;
            hcnt_q <= '0;
        end
        else if (hold_q)
        begin
            if (cfg_q.hold == pqt_pkg::PQT_HOLD_TIME)
            begin
                hcnt_q <= hcnt_q + 1'b1;
                if (hcnt_q + 1'b1 >= hold_val_q)
                    hold_q <= 1'b0;
            end
            else if (cfg_q.hold == pqt_pkg::PQT_HOLD_EVENTS)
            begin
                if (qualified ? fire_qual : fire_pat)
                begin
                    hcnt_q <= hcnt_q + 1'b1;
                    if (hcnt_q + 1'b1 >= hold_val_q)
                        hold_q <= 1'b0;
                end
            end
            else
                hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            trigger_out <= 1'b0;
        else
            trigger_out <= fire_any;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            trig_count_q <= '0;
        else if (fire_any)
            trig_count_q <= trig_count_q + 1'b1;
    end

    // ==========================================================
    // Read data
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata_q <= '0;
        else if (avs_read)
        begin
            case ({2'b00, avs_address[3:2], 2'b00})
                6'(pqt_pkg::REG_CTRL): rdata_q <= {19'h0, cfg_q.slope_neg, cfg_q.source,
                    cfg_q.use_absent, cfg_q.wait_kind, cfg_q.hold, cfg_q.on_exit,
                    cfg_q.mode, cfg_q.enable};
                6'(pqt_pkg::REG_PAT): rdata_q <= {19'h0, pat_q.level, 3'h0, pat_q.care};
                6'(pqt_pkg::REG_HOLD): rdata_q <= 32'(hold_val_q);
                default: rdata_q <= {13'h0, trig_count_q, armed_q, hold_q, pat_now};
            endcase
        end
    end

    assign avs_readdata = rdata_q;

endmodule : pqt_trigger

// ### sim/pqt_comp_model.sv
/* Comparator model: one threshold per input, four channels then external.
   Assumes the bench never sets a source exactly on its threshold. */
`timescale 1ns/100ps
module pqt_comp_model
(
    input wire logic [4:0][15:0] src_mv,
    input wire logic [4:0][15:0] thr_mv,
    output logic [4:0] comp_state
);
    // ==========
    // Threshold compare
    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            comp_state[i] = $signed(src_mv[i]) > $signed(thr_mv[i]);
        end
    end
endmodule : pqt_comp_model

// ### sim/pqt_trigger_monitor.sv
/* Checker bound to pqt_trigger; sees its ports only.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module pqt_trigger_monitor
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [pqt_pkg::N_IN-1:0] comp_state,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic trigger_out
);
    // ==========
    // Sequences
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_rd_wait;
        avs_read && avs_waitrequest;
    endsequence
    // Six quiet cycles outlast the synchroniser and edge pipeline
    sequence s_quiet;
        (!avs_write && $stable(comp_state)) [*6];
    endsequence
    // ==========
    // Properties
    a_wr_no_wait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write was stalled");
    a_idle_no_wait: assert property (!avs_read |-> !avs_waitrequest)
        else $error("wait without read");
    a_rd_first_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
        else $error("read answered at once");
    a_rd_answer: assert property (s_rd_wait ##1 avs_read |-> !avs_waitrequest)
        else $error("read not answered");
    a_rd_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved");
    a_trig_pulse: assert property (trigger_out |=> !trigger_out)
        else $error("trigger longer than one cycle");
    a_reset_quiet: assert property ($fell(reset) |-> !trigger_out && avs_readdata == 32'h0)
        else $error("outputs not cleared");
    a_quiet_no_trig: assert property (s_quiet |-> !trigger_out)
        else $error("trigger without cause");
endmodule : pqt_trigger_monitor
bind pqt_trigger pqt_trigger_monitor i_pqt_trigger_monitor
(
    .clk(clk),
    .reset(reset),
    .comp_state(comp_state),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .trigger_out(trigger_out)
);

// ### sim/pqt_trigger_test.sv
/* Self-checking bench for pqt_trigger driven through a comparator model.
   Assumes the port checker is bound from its own file. */
`timescale 1ns/100ps
module pqt_trigger_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic trigger_out;
    logic [4:0] comp_state;
    logic [4:0][15:0] src_mv = '0;
    logic [4:0][15:0] thr_mv = '0;
    int n_mismatch = 0;
    int compares = 0;
    int n_trig = 0;
    int cyc = 0;
    logic [31:0] q_rd[$];
    int q_tr[$];
    event chk_ev;
    logic [4:0] care, lvl, s;
    logic pp, p;

    pqt_comp_model i_pqt_comp_model
    (
        .src_mv(src_mv),
        .thr_mv(thr_mv),
        .comp_state(comp_state)
    );
    pqt_trigger i_pqt_trigger
    (
        .clk(clk),
        .reset(reset),
        .comp_state(comp_state),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .trigger_out(trigger_out)
    );

    // ==========
    // Clock, timeout and result watcher
    initial forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    always @(posedge clk)
    begin
        if (trigger_out === 1'b1)
            n_trig++;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            cmp({31'h0, avs_readdata[0]}, q_rd.pop_front());
    end
    always @(chk_ev)
    begin
        cmp(32'(n_trig), 32'(q_tr.pop_front()));
        n_trig = 0;
    end

    // ==========
    // Tasks
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic e);
        q_rd.push_back({31'h0, e});
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
    endtask : rd
    // Offsets keep each source clear of its threshold
    task st(input logic [4:0] v, input int n = 8);
        @(posedge clk);
        for (int i = 0; i < 5; i++)
            src_mv[i] <= thr_mv[i] + (v[i] ? 16'(1 + $urandom % 99) : -16'(1 + $urandom % 99));
        repeat (n) @(posedge clk);
    endtask : st
    // States are applied first byte first
    task run(input int n, input logic [39:0] v);
        for (int i = n - 1; i >= 0; i--)
            st(v[8 * i +: 5]);
    endtask : run
    task chk(input int n);
        @(negedge clk);
        q_tr.push_back(n);
        -> chk_ev;
    endtask : chk
    // Qualified modes always take the external input as source
    task cfg(pqt_pkg::pqt_mode_t m, logic ex, pqt_pkg::pqt_hold_t h, pqt_pkg::pqt_wait_t w,
        logic ab, logic ng);
        wr(pqt_pkg::REG_CTRL, {19'h0, ng, 3'h4, ab, w, h, ex, m, 1'b1});
    endtask : cfg
    task end_sim;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // ==========
    // Scenarios
    initial
    begin
        void'($urandom(72949));
        for (int i = 0; i < 5; i++)
            thr_mv[i] = 16'($urandom % 2000) - 16'h03E8;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        care = 5'($urandom);
        lvl = 5'($urandom);
        s = 5'($urandom);
        st(s);
        pp = ((s ~^ lvl) & care) == care;
        wr(pqt_pkg::REG_PAT, {19'h0, lvl, 3'h0, care});
        for (int ex = 0; ex < 2; ex++)
        begin
            cfg(pqt_pkg::PQT_MODE_PATTERN, ex[0], pqt_pkg::PQT_HOLD_NONE, pqt_pkg::PQT_WAIT_NOW, 0, 0);
            chk(0);
            repeat (24)
            begin
                s = 5'($urandom);
                p = ((s ~^ lvl) & care) == care;
                st(s);
                chk(ex ? pp & ~p : p & ~pp);
                rd(pqt_pkg::REG_WAIT, p);
                pp = p;
            end
        end
        wr(pqt_pkg::REG_PAT, {19'h0, 5'h01, 3'h0, 5'h01});
        cfg(pqt_pkg::PQT_MODE_PATTERN, 0, pqt_pkg::PQT_HOLD_TIME, pqt_pkg::PQT_WAIT_NOW, 0, 0);
        wr(pqt_pkg::REG_HOLD, 32'h0000_003C);
        run(4, 40'h00_01_00_01);
        chk(1);
        st(5'h00, 70);
        st(5'h01);
        chk(1);
        // Let the time hold-off run out first, so no stale hold carries into event mode
        st(5'h00, 70);
        cfg(pqt_pkg::PQT_MODE_PATTERN, 0, pqt_pkg::PQT_HOLD_EVENTS, pqt_pkg::PQT_WAIT_NOW, 0, 0);
        wr(pqt_pkg::REG_HOLD, 32'h0000_0002);
        run(5, 40'h01_00_01_00_01);
        run(3, 40'h00_01_00);
        chk(2);
        wr(pqt_pkg::REG_PAT, {19'h0, 5'h01, 3'h0, 5'h11});
        cfg(pqt_pkg::PQT_MODE_STATE, 0, pqt_pkg::PQT_HOLD_NONE, pqt_pkg::PQT_WAIT_NOW, 0, 0);
        chk(0);
        run(2, 40'h00_01);
        chk(0);
        st(5'h11);
        chk(1);
        run(3, 40'h01_00_10);
        chk(0);
        cfg(pqt_pkg::PQT_MODE_STATE, 0, pqt_pkg::PQT_HOLD_NONE, pqt_pkg::PQT_WAIT_NOW, 1, 0);
        // Absence must begin after the switch to arm the qualifier
        run(3, 40'h01_00_10);
        chk(1);
        run(2, 40'h01_11);
        chk(0);
        cfg(pqt_pkg::PQT_MODE_EDGE, 0, pqt_pkg::PQT_HOLD_NONE, pqt_pkg::PQT_WAIT_NOW, 0, 0);
        run(4, 40'h00_01_00_10);
        chk(1);
        run(2, 40'h00_10);
        chk(0);
        cfg(pqt_pkg::PQT_MODE_STATE, 0, pqt_pkg::PQT_HOLD_NONE, pqt_pkg::PQT_WAIT_DELAY, 0, 0);
        wr(pqt_pkg::REG_WAIT, 32'h0000_0028);
        run(3, 40'h00_01_11);
        chk(0);
        st(5'h01, 40);
        st(5'h11);
        chk(1);
        run(3, 40'h00_01_11);
        chk(0);
        cfg(pqt_pkg::PQT_MODE_STATE, 0, pqt_pkg::PQT_HOLD_NONE, pqt_pkg::PQT_WAIT_WITHIN, 0, 0);
        run(3, 40'h00_01_11);
        chk(1);
        st(5'h01, 50);
        st(5'h11);
        chk(0);
        cfg(pqt_pkg::PQT_MODE_STATE, 0, pqt_pkg::PQT_HOLD_NONE, pqt_pkg::PQT_WAIT_EVENTS, 0, 1);
        wr(pqt_pkg::REG_WAIT, 32'h0000_0003);
        run(5, 40'h10_11_01_11_01);
        chk(0);
        run(2, 40'h11_01);
        chk(1);
        // Leave the pattern without a source event, since a reached count keeps firing
        run(4, 40'h11_10_00_01);
        run(4, 40'h11_01_11_01);
        chk(0);
        repeat (10) @(posedge clk);
        end_sim();
    end
endmodule : pqt_trigger_test
